// *** sim/secp_link_chk.sv ***
// checker for the four-wire link between host end and device end
// assumes it watches the interface signals in the MCLK_I domain
`timescale 1ns/1ps
`default_nettype none
module secp_link_chk
  import secp_pkg::*;
#(
  parameter int PROG_CYC = 50
) (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic ARST_N_I,
  // link and status
  input wire logic chip_sel,
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  input wire logic serial_data_out_oe,
  input wire logic serial_data_line,
  input wire logic BUSY_O
);
  logic [7:0] low_ff;
  logic       first_ff;
  int         busy_ff;

  // cycles chip select has been low, saturating
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) low_ff <= 8'hFF;
    else if (chip_sel) low_ff <= 8'h00;
    else if (low_ff != 8'hFF) low_ff <= low_ff + 8'h01;
  end
  // no serial clock edge yet in this frame
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) first_ff <= 1'b1;
    else if (!chip_sel) first_ff <= 1'b1;
    else if (serial_clock_in) first_ff <= 1'b0;
  end
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) busy_ff <= 0;
    else if (BUSY_O) busy_ff <= busy_ff + 1;
    else busy_ff <= 0;
  end

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!ARST_N_I);

  property p_start_bit;
    $rose(serial_clock_in) && first_ff |-> serial_data_in;
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("first bit of a frame is not one");
  property p_cs_gap;
    $rose(chip_sel) |-> low_ff >= CS_LOW_CYC;
  endproperty
  a_cs_gap: assert property (p_cs_gap)
    else $error("chip select low time too short");
  property p_sk_in_frame;
    $rose(serial_clock_in) |-> chip_sel;
  endproperty
  a_sk_in_frame: assert property (p_sk_in_frame)
    else $error("serial clock rose with chip select low");
  property p_oe_off;
    !chip_sel [*6] |-> !serial_data_out_oe;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("data out driven while deselected");
  property p_busy_start;
    $rose(BUSY_O) |-> !chip_sel && low_ff <= 8'h08;
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("programming not started by select falling");
  property p_busy_len;
    $fell(BUSY_O) |-> busy_ff >= PROG_CYC - 1 && busy_ff <= PROG_CYC + 4;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("programming time wrong");
  property p_busy_out;
    BUSY_O && serial_data_out_oe |-> !serial_data_line;
  endproperty
  a_busy_out: assert property (p_busy_out)
    else $error("status not low while busy");
  property p_status_valid;
    $rose(chip_sel) && BUSY_O |-> ##[1:25] serial_data_out_oe;
  endproperty
  a_status_valid: assert property (p_status_valid)
    else $error("status not driven after reselect");
  property p_ready;
    $fell(BUSY_O) && chip_sel |-> ##[1:6] serial_data_out_oe && serial_data_line;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready not shown after programming");

  c_write: cover property ($rose(BUSY_O));
  c_poll: cover property ($fell(BUSY_O) && chip_sel);
  c_read: cover property (serial_data_out_oe && !BUSY_O && serial_clock_in);
endmodule // secp_link_chk
`default_nettype wire

// *** sim/tb.sv ***
// testbench: host end and device end joined by the link interface
// assumes the host makes the serial clock; commands driven at falling MCLK edges
`timescale 1ns/1ps
`default_nettype none
module tb
  import secp_pkg::*;
;
  localparam int PCYC = 50;
  logic              mclk      = 1'b0;
  logic              arst_n    = 1'b0;
  logic              cmd_valid = 1'b0;
  secp_cmd_t         cmd_op    = CMD_READ;
  logic [5:0]        cmd_addr  = 6'h00;
  logic [WORD_W-1:0] cmd_wdata = 16'h0000;
  logic              cmd_ready;
  logic              rsp_valid;
  logic              busy;
  logic              busy_seen = 1'b0;
  logic              stat_left = 1'b0;
  logic [5:0]        ra_seen   = 6'h00;
  logic [WORD_W-1:0] rsp_data;
  logic [WORD_W-1:0] rsp_word  = 16'h0000;
  logic [31:0]       din_sr    = 32'h0;
  logic [31:0]       line_sr   = 32'h0;
  logic [31:0]       oe_sr     = 32'h0;
  int                bit_cnt   = 0;
  int                errors    = 0;
  int                checked   = 0;
  int                cyc       = 0;
  int                fcnt[$];
  logic [31:0]       fdin[$];
  logic [31:0]       fline[$];
  logic [31:0]       foe[$];

  secp_link_if secp_link_if_i ();
  secp_host #(.WORDS(DEF_WORDS), .FIELD(DEF_FIELD), .DIV(SK_DIV)) secp_host_i (
    .MCLK_I(mclk), .ARST_N_I(arst_n), .CMD_VALID_I(cmd_valid), .CMD_OP_I(cmd_op),
    .CMD_ADDR_I(cmd_addr), .CMD_WDATA_I(cmd_wdata), .CMD_READY_O(cmd_ready),
    .RSP_VALID_O(rsp_valid), .RSP_DATA_O(rsp_data), .LINK(secp_link_if_i));
  secp_device #(.WORDS(DEF_WORDS), .FIELD(DEF_FIELD), .PROG_CYC(PCYC)) secp_device_i (
    .MCLK_I(mclk), .ARST_N_I(arst_n), .LINK(secp_link_if_i), .BUSY_O(busy));
  secp_link_chk #(.PROG_CYC(PCYC)) secp_link_chk_i (
    .MCLK_I(mclk), .ARST_N_I(arst_n), .chip_sel(secp_link_if_i.chip_sel),
    .serial_clock_in(secp_link_if_i.serial_clock_in),
    .serial_data_in(secp_link_if_i.serial_data_in),
    .serial_data_out_oe(secp_link_if_i.serial_data_out_oe),
    .serial_data_line(secp_link_if_i.serial_data_line), .BUSY_O(busy));

  initial begin
    forever #10 mclk = ~mclk;
  end
  // frame monitor: bits seen at each serial clock rise
  always @(posedge secp_link_if_i.serial_clock_in) begin
    din_sr <= {din_sr[30:0], secp_link_if_i.serial_data_in};
    line_sr <= {line_sr[30:0], secp_link_if_i.serial_data_line};
    oe_sr <= {oe_sr[30:0], secp_link_if_i.serial_data_out_oe};
    bit_cnt <= bit_cnt + 1;
  end
  // read address left after the last serial clock of a frame
  always @(negedge secp_link_if_i.serial_clock_in) begin
    ra_seen <= secp_device_i.ra_ff;
  end
  always @(negedge secp_link_if_i.chip_sel) begin
    if (bit_cnt > 0) begin
      fcnt.push_back(bit_cnt);
      fdin.push_back(din_sr);
      fline.push_back(line_sr);
      foe.push_back(oe_sr);
    end
    bit_cnt <= 0;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (busy === 1'b1) busy_seen <= 1'b1;
    if (rsp_valid === 1'b1) rsp_word <= rsp_data;
    if (cyc == 40000) begin
      errors++;
      results();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cmd(input secp_cmd_t op, input logic [5:0] a, input logic [15:0] d);
    int n;
    n = 0;
    fcnt.delete();
    fdin.delete();
    fline.delete();
    foe.delete();
    busy_seen = 1'b0;
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    while (cmd_ready !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    cmd_valid = 1'b0;
    while (cmd_ready !== 1'b1 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    check("command done", n < 5000, 1'b1);
  endtask
  task automatic t_write(input logic [5:0] a, input logic [15:0] d, input int nfr);
    cmd(CMD_WRITE, a, d);
    check("frames", fcnt.size(), nfr);
    if (nfr == 2) check("enable", fdin[0][8:4], 5'h13);
    check("write bits", fcnt[nfr-1], 25);
    check("write frame", fdin[nfr-1][24:0], {3'h5, a, d});
    check("write no out", foe[nfr-1], {7'h00, stat_left && nfr == 1, 24'h000000});
    check("programmed", busy_seen, 1'b1);
    stat_left = 1'b1;
  endtask
  task automatic t_read(input logic [5:0] a, input logic [15:0] d);
    cmd(CMD_READ, a, 16'h0000);
    check("read word", rsp_word, d);
    check("read bits", fcnt[0], 25);
    check("read frame", fdin[0][24:16], {3'h6, a});
    check("quiet head", foe[0][23:16], 8'h00);
    check("status held", {foe[0][24], fline[0][24]}, {2{stat_left}});
    check("dummy", {foe[0][15], fline[0][15]}, 2'h2);
    check("line bits", fline[0][14:0], d[15:1]);
    check("next address", ra_seen, 6'(a + 6'h01));
    stat_left = 1'b0;
  endtask
  task automatic t_disable();
    cmd(CMD_DIS, 6'h00, 16'h0000);
    stat_left = 1'b0;
    check("disable", {fcnt[0][7:0], fdin[0][8:4]}, {8'h09, 5'h10});
    t_read(6'h3F, 16'hA5C3);
    t_write(6'h15, 16'h0F0F, 2);
    t_read(6'h15, 16'h0F0F);
  endtask
  task automatic t_reset();
    @(negedge mclk);
    arst_n = 1'b0;
    repeat (5) @(negedge mclk);
    check("idle busy", busy, 1'b0);
    check("idle line", secp_link_if_i.serial_data_line, 1'b0);
    check("idle enable", secp_device_i.en_ff, 1'b0);
    stat_left = 1'b0;
    arst_n = 1'b1;
    t_read(6'h00, 16'h5A3C);
    t_write(6'h01, 16'hFFFF, 2);
  endtask
  task automatic results();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (5) @(negedge mclk);
    arst_n = 1'b1;
    check("ready", cmd_ready, 1'b1);
    t_write(6'h3F, 16'hA5C3, 2);
    t_write(6'h00, 16'h5A3C, 1);
    t_read(6'h3F, 16'hA5C3);
    t_read(6'h00, 16'h5A3C);
    t_disable();
    t_reset();
    results();
  end
endmodule // tb
`default_nettype wire

// *** verilog/secp_device.sv ***
// device end: instruction decoder on the serial clock, memory and programming timer on MCLK_I
// assumes a host on secp_link_if; the serial clock only runs while chip select is high
`timescale 1ns/1ps
`default_nettype none
module secp_device
  import secp_pkg::*;
#(
  parameter int WORDS    = DEF_WORDS,
  parameter int FIELD    = DEF_FIELD,
  parameter int PROG_CYC = PROG_CYC_DEF
) (
  // core clock and reset
  input  wire logic MCLK_I,
  input  wire logic ARST_N_I,
  // link
  secp_link_if.dev  LINK,
  // status
  output logic      BUSY_O
);
  localparam int AW  = $clog2(WORDS);
  localparam int CW  = $clog2(FIELD + WORD_W + 1);
  localparam int PCW = $clog2(PROG_CYC + 1);

  typedef enum logic [2:0] {L_IDLE, L_OP, L_ADDR, L_WDATA, L_READ, L_DONE} secp_lstate_t;

  // link domain
  secp_lstate_t      st_ff;
  logic [1:0]        op_ff;
  logic [CW-1:0]     cnt_ff;
  logic [FIELD-1:0]  fld_ff;
  logic [AW-1:0]     ra_ff;
  logic              lk_do_ff;
  logic              lk_rd_ff;
  logic              lk_go_ff;
  logic              en_ff;
  logic              wok_ff;
  logic [AW-1:0]     wa_ff;
  logic [WORD_W-1:0] wd_ff;
  logic              lrst_n;
  logic [FIELD-1:0]  fnext;
  logic              flast;
  logic [3:0]        rbit;

  // core domain
  logic [4:0]        s1_ff;
  logic [4:0]        s2_ff;
  logic              csd_ff;
  logic              busy_ff;
  logic              wused_ff;
  logic              stat_ff;
  logic [PCW-1:0]    pcnt_ff;
  logic [AW-1:0]     ca_ff;
  logic [WORD_W-1:0] cd_ff;
  logic              do_o_ff;
  logic              oe_ff;
  logic [WORD_W-1:0] mem_ff [WORDS];
  logic              cs_s;
  logic              rd_s;
  logic              dbit_s;
  logic              go_s;
  logic              wok_s;

  // decoder state is cleared whenever select is low
  assign lrst_n = ARST_N_I & LINK.chip_sel;
  assign fnext  = {fld_ff[FIELD-2:0], LINK.serial_data_in};
  assign flast  = (st_ff == L_ADDR) && (cnt_ff == CW'(FIELD - 1));
  assign rbit   = 4'(WORD_W - 1) - cnt_ff[3:0];

  // instruction sequencer
  always_ff @(posedge LINK.serial_clock_in or negedge lrst_n) begin
    if (!lrst_n) begin
      st_ff    <= L_IDLE;
      op_ff    <= 2'h0;
      cnt_ff   <= '0;
      fld_ff   <= '0;
      ra_ff    <= '0;
      lk_do_ff <= 1'b0;
      lk_rd_ff <= 1'b0;
      lk_go_ff <= 1'b0;
    end else begin
      case (st_ff)
        L_IDLE: begin
          if (LINK.serial_data_in) begin
            st_ff    <= L_OP;
            cnt_ff   <= '0;
            lk_go_ff <= 1'b1;
          end
        end
        L_OP: begin
          op_ff  <= {op_ff[0], LINK.serial_data_in};
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff == CW'(1)) begin
            st_ff  <= L_ADDR;
            cnt_ff <= '0;
          end
        end
        L_ADDR: begin
          fld_ff <= fnext;
          cnt_ff <= cnt_ff + 1'b1;
          if (flast) begin
            cnt_ff <= '0;
            if (op_ff == OP_READ) begin
              st_ff    <= L_READ;
              ra_ff    <= fnext[AW-1:0];
              lk_rd_ff <= 1'b1;
              lk_do_ff <= 1'b0;
            end else if (op_ff == OP_WRITE) begin
              st_ff <= L_WDATA;
            end else begin
              st_ff <= L_DONE;
            end
          end
        end
        L_WDATA: begin
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff == CW'(WORD_W - 1)) begin
            st_ff <= L_DONE;
          end
        end
        L_READ: begin
          lk_do_ff <= mem_ff[ra_ff][rbit];
          cnt_ff   <= cnt_ff + 1'b1;
          if (cnt_ff[3:0] == 4'hF) begin
            cnt_ff <= '0;
            ra_ff  <= ra_ff + 1'b1;
          end
        end
        default: begin
          st_ff <= st_ff;
        end
      endcase
    end
  end

  // write enable latch and captured write; survives select low so the core can take it
  always_ff @(posedge LINK.serial_clock_in or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      en_ff  <= 1'b0;
      wok_ff <= 1'b0;
      wa_ff  <= '0;
      wd_ff  <= '0;
    end else begin
      if ((st_ff == L_IDLE && LINK.serial_data_in) || st_ff == L_DONE) begin
        wok_ff <= 1'b0;
      end
      if (flast && op_ff == OP_MISC) begin
        if (fnext[FIELD-1 -: 2] == MISC_EN) begin
          en_ff <= 1'b1;
        end else if (fnext[FIELD-1 -: 2] == MISC_DIS) begin
          en_ff <= 1'b0;
        end
      end
      if (flast && op_ff == OP_WRITE) begin
        wa_ff <= fnext[AW-1:0];
      end
      if (st_ff == L_WDATA) begin
        wd_ff <= {wd_ff[WORD_W-2:0], LINK.serial_data_in};
        if (cnt_ff == CW'(WORD_W - 1)) begin
          wok_ff <= en_ff;
        end
      end
    end
  end

  // level synchronisers into the core clock
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      s1_ff <= 5'h00;
      s2_ff <= 5'h00;
    end else begin
      s1_ff <= {LINK.chip_sel, lk_rd_ff, lk_do_ff, lk_go_ff, wok_ff};
      s2_ff <= s1_ff;
    end
  end

  assign cs_s   = s2_ff[4];
  assign rd_s   = s2_ff[3];
  assign dbit_s = s2_ff[2];
  assign go_s   = s2_ff[1];
  assign wok_s  = s2_ff[0];

  // programming timer; wa/wd are stable while the synced write flag is seen
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      csd_ff  <= 1'b0;
      wused_ff <= 1'b0;
      busy_ff <= 1'b0;
      stat_ff <= 1'b0;
      pcnt_ff <= '0;
      ca_ff   <= '0;
      cd_ff   <= '0;
    end else begin
      csd_ff <= cs_s;
      // a captured write is consumed by the first select fall; the status poll
      // that follows must not start a second programming cycle
      if (!wok_s) begin
        wused_ff <= 1'b0;
      end else if (csd_ff && !cs_s) begin
        wused_ff <= 1'b1;
      end
      if (go_s) begin
        stat_ff <= 1'b0;
      end
      if (csd_ff && !cs_s && wok_s && !wused_ff && !busy_ff) begin
        busy_ff <= 1'b1;
        stat_ff <= 1'b1;
        pcnt_ff <= PCW'(PROG_CYC - 1);
        ca_ff   <= wa_ff;
        cd_ff   <= wd_ff;
      end else if (busy_ff) begin
        pcnt_ff <= pcnt_ff - 1'b1;
        if (pcnt_ff == '0) begin
          busy_ff <= 1'b0;
        end
      end
    end
  end

  // array is nonvolatile content, no reset
  always_ff @(posedge MCLK_I) begin
    if (busy_ff && pcnt_ff == '0) begin
      mem_ff[ca_ff] <= cd_ff;
    end
  end

  // serial output driver
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      do_o_ff <= 1'b0;
      oe_ff   <= 1'b0;
    end else begin
      oe_ff   <= cs_s & (rd_s | stat_ff);
      do_o_ff <= rd_s ? dbit_s : ~busy_ff;
    end
  end

  assign LINK.serial_data_out    = do_o_ff;
  assign LINK.serial_data_out_oe = oe_ff;
  assign BUSY_O                  = busy_ff;
endmodule  // secp_device
`default_nettype wire

// *** verilog/secp_host.sv ***
// host end: turns word commands into serial frames, polls status after writes
// assumes a 50 MHz MCLK_I; the serial clock is MCLK_I divided by SK_DIV
`timescale 1ns/1ps
`default_nettype none
module secp_host
  import secp_pkg::*;
#(
  parameter int WORDS = DEF_WORDS,
  parameter int FIELD = DEF_FIELD,
  parameter int DIV   = SK_DIV
) (
  // clock and reset
  input  wire logic             MCLK_I,
  input  wire logic             ARST_N_I,
  // command
  input  wire logic             CMD_VALID_I,
  input  wire secp_cmd_t        CMD_OP_I,
  input  wire logic [$clog2(WORDS)-1:0] CMD_ADDR_I,
  input  wire logic [WORD_W-1:0] CMD_WDATA_I,
  output logic                  CMD_READY_O,
  // read answer
  output logic                  RSP_VALID_O,
  output logic [WORD_W-1:0]     RSP_DATA_O,
  // link
  secp_link_if.host             LINK
);
  localparam int AW   = $clog2(WORDS);
  localparam int FW   = 3 + FIELD + WORD_W;
  localparam int CW   = $clog2(FW + 2);
  localparam int PHW  = $clog2(DIV);
  localparam int GW   = $clog2(STAT_CYC + CS_LOW_CYC + 1);
  localparam int HALF = DIV / 2;

  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_GAP, H_POLL} secp_hstate_t;

  secp_hstate_t      st_ff;
  logic [PHW-1:0]    ph_ff;
  logic [CW-1:0]     per_ff;
  logic [CW-1:0]     nper_ff;
  logic [FW-1:0]     frm_ff;
  logic [GW-1:0]     gcnt_ff;
  logic              cs_ff;
  logic              sk_ff;
  logic              di_ff;
  logic              isrd_ff;
  logic              poll_ff;
  logic              pend_ff;
  logic              ensent_ff;
  logic              rdy_ff;
  logic              rv_ff;
  logic [WORD_W-1:0] rsh_ff;
  logic [WORD_W-1:0] rdat_ff;
  logic [AW-1:0]     pa_ff;
  logic [WORD_W-1:0] pd_ff;
  logic [1:0]        dsy_ff;

  function automatic logic [FW-1:0] mkf(input logic [1:0] op, input logic [FIELD-1:0] f,
                                        input logic [WORD_W-1:0] d);
    mkf = {1'b1, op, f, d};
  endfunction

  function automatic logic [FIELD-1:0] fa(input logic [AW-1:0] a);
    fa = '0;
    fa[AW-1:0] = a;
  endfunction

  function automatic logic [FIELD-1:0] fm(input logic [1:0] c);
    fm = '0;
    fm[FIELD-1 -: 2] = c;
  endfunction

  // data line synchroniser
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      dsy_ff <= 2'h0;
    end else begin
      dsy_ff <= {dsy_ff[0], LINK.serial_data_line};
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      st_ff     <= H_IDLE;
      ph_ff     <= '0;
      per_ff    <= '0;
      nper_ff   <= '0;
      frm_ff    <= '0;
      gcnt_ff   <= '0;
      cs_ff     <= 1'b0;
      sk_ff     <= 1'b0;
      di_ff     <= 1'b0;
      isrd_ff   <= 1'b0;
      poll_ff   <= 1'b0;
      pend_ff   <= 1'b0;
      ensent_ff <= 1'b0;
      rdy_ff    <= 1'b1;
      rv_ff     <= 1'b0;
      rsh_ff    <= '0;
      rdat_ff   <= '0;
      pa_ff     <= '0;
      pd_ff     <= '0;
    end else begin
      rv_ff <= 1'b0;
      case (st_ff)
        H_IDLE: begin
          if (CMD_VALID_I && rdy_ff) begin
            rdy_ff  <= 1'b0;
            st_ff   <= H_SHIFT;
            cs_ff   <= 1'b1;
            ph_ff   <= '0;
            per_ff  <= '0;
            nper_ff <= CW'(3 + FIELD);
            isrd_ff <= 1'b0;
            pa_ff   <= CMD_ADDR_I;
            pd_ff   <= CMD_WDATA_I;
            case (CMD_OP_I)
              CMD_READ: begin
                frm_ff  <= mkf(OP_READ, fa(CMD_ADDR_I), '0);
                nper_ff <= CW'(3 + FIELD + WORD_W);
                isrd_ff <= 1'b1;
              end
              CMD_WRITE: begin
                if (ensent_ff) begin
                  frm_ff  <= mkf(OP_WRITE, fa(CMD_ADDR_I), CMD_WDATA_I);
                  nper_ff <= CW'(FW);
                  poll_ff <= 1'b1;
                end else begin
                  frm_ff    <= mkf(OP_MISC, fm(MISC_EN), '0);
                  ensent_ff <= 1'b1;
                  pend_ff   <= 1'b1;
                end
              end
              CMD_EN: begin
                frm_ff    <= mkf(OP_MISC, fm(MISC_EN), '0);
                ensent_ff <= 1'b1;
              end
              default: begin
                frm_ff    <= mkf(OP_MISC, fm(MISC_DIS), '0);
                ensent_ff <= 1'b0;
              end
            endcase
          end
        end
        H_SHIFT: begin
          ph_ff <= (ph_ff == PHW'(DIV - 1)) ? '0 : ph_ff + 1'b1;
          if (ph_ff == '0) begin
            di_ff  <= frm_ff[FW-1];
            frm_ff <= {frm_ff[FW-2:0], 1'b0};
          end
          if (ph_ff == PHW'(HALF - 1)) begin
            rsh_ff <= {rsh_ff[WORD_W-2:0], dsy_ff[1]};
            if (per_ff == nper_ff) begin
              cs_ff   <= 1'b0;
              di_ff   <= 1'b0;
              st_ff   <= H_GAP;
              gcnt_ff <= GW'(CS_LOW_CYC - 1);
              rv_ff   <= isrd_ff;
              rdat_ff <= {rsh_ff[WORD_W-2:0], dsy_ff[1]};
            end else begin
              sk_ff <= 1'b1;
            end
          end
          if (ph_ff == PHW'(DIV - 1)) begin
            sk_ff  <= 1'b0;
            per_ff <= per_ff + 1'b1;
          end
        end
        H_GAP: begin
          gcnt_ff <= gcnt_ff - 1'b1;
          if (gcnt_ff == '0) begin
            if (poll_ff) begin
              cs_ff   <= 1'b1;
              st_ff   <= H_POLL;
              gcnt_ff <= GW'(STAT_CYC - 1);
            end else if (pend_ff) begin
              pend_ff <= 1'b0;
              poll_ff <= 1'b1;
              frm_ff  <= mkf(OP_WRITE, fa(pa_ff), pd_ff);
              nper_ff <= CW'(FW);
              cs_ff   <= 1'b1;
              ph_ff   <= '0;
              per_ff  <= '0;
              st_ff   <= H_SHIFT;
            end else begin
              st_ff  <= H_IDLE;
              rdy_ff <= 1'b1;
            end
          end
        end
        default: begin
          if (gcnt_ff != '0) begin
            gcnt_ff <= gcnt_ff - 1'b1;
          end else if (dsy_ff[1]) begin
            cs_ff   <= 1'b0;
            poll_ff <= 1'b0;
            st_ff   <= H_GAP;
            gcnt_ff <= GW'(CS_LOW_CYC - 1);
          end
        end
      endcase
    end
  end

  assign LINK.chip_sel        = cs_ff;
  assign LINK.serial_clock_in = sk_ff;
  assign LINK.serial_data_in  = di_ff;
  assign CMD_READY_O          = rdy_ff;
  assign RSP_VALID_O          = rv_ff;
  assign RSP_DATA_O           = rdat_ff;
endmodule  // secp_host
`default_nettype wire

// *** verilog/secp_link_if.sv ***
// four-wire link between host end and device end of the serial eeprom port
// assumes the bench connects both modports; data out is resolved here from its enable
`timescale 1ns/1ps
`default_nettype none
interface secp_link_if;
  logic chip_sel;
  logic serial_clock_in;
  logic serial_data_in;
  logic serial_data_out;
  logic serial_data_out_oe;
  logic serial_data_line;

  // undriven line reads low
  assign serial_data_line = serial_data_out_oe ? serial_data_out : 1'b0;

  modport dev (
    input  chip_sel,
    input  serial_clock_in,
    input  serial_data_in,
    output serial_data_out,
    output serial_data_out_oe
  );
  modport host (
    output chip_sel,
    output serial_clock_in,
    output serial_data_in,
    input  serial_data_line
  );
endinterface
`default_nettype wire

// *** verilog/secp_pkg.sv ***
// shared constants of the serial eeprom command port: opcodes, sizes, timing counts
// assumes a 50 MHz core clock on both ends
`default_nettype none
package secp_pkg;
  // word and array organisation
  localparam int         WORD_W       = 16;
  localparam int         DEF_WORDS    = 64;
  localparam int         DEF_FIELD    = 6;
  // opcodes and the function codes of the misc group
  localparam logic [1:0] OP_READ      = 2'h2;
  localparam logic [1:0] OP_WRITE     = 2'h1;
  localparam logic [1:0] OP_MISC      = 2'h0;
  localparam logic [1:0] MISC_EN      = 2'h3;
  localparam logic [1:0] MISC_DIS     = 2'h0;
  // timing
  localparam int         MCLK_NS      = 20;
  localparam int         PROG_TIME_US = 10000;
  localparam int         PROG_CYC_DEF = PROG_TIME_US * 1000 / MCLK_NS;
  localparam int         CS_LOW_NS    = 250;
  localparam int         CS_LOW_CYC   = (CS_LOW_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int         STAT_NS      = 500;
  localparam int         STAT_CYC     = (STAT_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int         SK_DIV       = 8;
  // host command codes
  typedef enum logic [1:0] {CMD_READ, CMD_WRITE, CMD_EN, CMD_DIS} secp_cmd_t;
endpackage
`default_nettype wire
